/* File: hdl/ccr_top.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ccr_defs.svh"
// ----------------------------------------
// charge counter readout, apb slave
// ----------------------------------------
module ccr_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire ccr_pkg::ccr_word_t pwdata,
  output ccr_pkg::ccr_word_t      prdata_q,
  output logic                    pready_q,
  output logic                    pslverr_q,
  input  wire logic               pulse_a,
  input  wire logic               pulse_b,
  input  wire logic               mode_deep_sleep
);
  // ----------------------------------------
  // pin synchronisation
  // ----------------------------------------
  logic [`CCR_SYNC_W-1:0] pins_s;

  ccr_sync #(.W(`CCR_SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({mode_deep_sleep, pulse_b, pulse_a}),
    .q       (pins_s)
  );

  logic pa_s;
  logic pb_s;
  logic sleep_s;
  assign pa_s    = pins_s[0];
  assign pb_s    = pins_s[1];
  assign sleep_s = pins_s[2];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  ccr_pkg::ccr_idx_t   widx;
  logic                aligned;
  logic                acc_first;
  logic                acc_done;
  logic                ctrl_hit;
  logic                stat_hit;
  logic                mapped;
  logic                err;
  ccr_pkg::ccr_presc_t presc_q;

  assign widx      = paddr[7:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  // one wait state lets read data leave a flop
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;
  assign ctrl_hit  = aligned & (widx == `CCR_IDX_CTRL);
  assign stat_hit  = aligned & (widx == `CCR_IDX_STAT);

  // ----------------------------------------
  // counters, shadows and read paths
  // ----------------------------------------
  ccr_pkg::ccr_count_t cnt      [`CCR_NUM_COUNTERS];
  ccr_pkg::ccr_byte_t  shadow_q [`CCR_NUM_COUNTERS];
  ccr_pkg::ccr_byte_t  rd_c     [`CCR_NUM_COUNTERS];
  logic [`CCR_NUM_COUNTERS-1:0] hi_hit;
  logic [`CCR_NUM_COUNTERS-1:0] lo_hit;
  logic [`CCR_NUM_COUNTERS-1:0] inh;
  logic [`CCR_NUM_COUNTERS-1:0] cen;
  logic [`CCR_NUM_COUNTERS-1:0] pin_of;

  // output a counts always; output b splits by energy mode
  assign cen    = {sleep_s, ~sleep_s, 1'b1};
  assign pin_of = {pb_s, pb_s, pa_s};

  genvar i;
  generate
    for (i = 0; i < `CCR_NUM_COUNTERS; i++) begin : g_cnt
      localparam ccr_pkg::ccr_idx_t HI = `CCR_IDX_A_HIGH + 6'(2 * i);
      localparam ccr_pkg::ccr_idx_t LO = HI + 6'h01;

      assign hi_hit[i] = aligned & (widx == HI);
      assign lo_hit[i] = aligned & (widx == LO);
      // hold through the whole transfer, setup phase included
      assign inh[i]    = psel & (hi_hit[i] | lo_hit[i]);
      assign rd_c[i]   = hi_hit[i] ? cnt[i][15:8] :
                         lo_hit[i] ? shadow_q[i] : `CCR_RST_BYTE;

      ccr_counter u_cnt (
        .pclk      (pclk),
        .presetn   (presetn),
        .pulse_lvl (pin_of[i]),
        .prescale  (presc_q),
        .count_en  (cen[i]),
        .inhibit   (inh[i]),
        .count_q   (cnt[i])
      );

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          shadow_q[i] <= `CCR_RST_BYTE;
        end else if (acc_first & ~pwrite & hi_hit[i]) begin
          shadow_q[i] <= cnt[i][7:0];
        end
      end

      property p_snap;
        @(posedge pclk) disable iff (!presetn)
        (acc_first && !pwrite && hi_hit[i]) |=>
          (shadow_q[i] == $past(cnt[i][7:0])) && (prdata_q[15:8] == 8'h00);
      endproperty
      a_snap: assert property (p_snap) else $error("shadow not taken on high read");

      property p_lo_rd;
        @(posedge pclk) disable iff (!presetn)
        (acc_first && !pwrite && lo_hit[i]) |=>
          prdata_q == {24'h0, $past(shadow_q[i])};
      endproperty
      a_lo_rd: assert property (p_lo_rd) else $error("low read not shadow");

      property p_hi_rd;
        @(posedge pclk) disable iff (!presetn)
        (acc_first && !pwrite && hi_hit[i]) |=>
          prdata_q == {24'h0, $past(cnt[i][15:8])};
      endproperty
      a_hi_rd: assert property (p_hi_rd) else $error("high read not live");

      property p_shd_keep;
        @(posedge pclk) disable iff (!presetn)
        !(acc_first && !pwrite && hi_hit[i]) |=> shadow_q[i] == $past(shadow_q[i]);
      endproperty
      a_shd_keep: assert property (p_shd_keep) else $error("shadow moved");

      property p_held;
        @(posedge pclk) disable iff (!presetn)
        (psel && (hi_hit[i] || lo_hit[i])) |=> cnt[i] == $past(cnt[i]);
      endproperty
      a_held: assert property (p_held) else $error("addressed counter moved");

      property p_mode_gate;
        @(posedge pclk) disable iff (!presetn)
        !cen[i] |=> cnt[i] == $past(cnt[i]);
      endproperty
      a_mode_gate: assert property (p_mode_gate) else $error("counter moved in other mode");

      // one rise at a prescale of one pulse must step the count by exactly one
      property p_step;
        @(posedge pclk) disable iff (!presetn)
        (cen[i] && !inh[i] && pin_of[i] && !$past(pin_of[i]) && presc_q == 3'h0) |=>
          cnt[i] == $past(cnt[i]) + 16'h0001;
      endproperty
      a_step: assert property (p_step) else $error("rise not counted once");
    end
  endgenerate

  ccr_pkg::ccr_byte_t cnt_byte;
  ccr_pkg::ccr_word_t rd_word;
  ccr_pkg::ccr_word_t stat_word;

  assign mapped    = (|hi_hit) | (|lo_hit) | ctrl_hit | stat_hit;
  // counter bytes are read only, a write to them is flagged
  assign err       = ~mapped | (pwrite & ~ctrl_hit);
  assign cnt_byte  = rd_c[0] | rd_c[1] | rd_c[2];
  assign stat_word = {29'h0, pb_s, pa_s, sleep_s};
  assign rd_word   = ctrl_hit ? {29'h0, presc_q} :
                     stat_hit ? stat_word : {24'h0, cnt_byte};

  // ----------------------------------------
  // bus response
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `CCR_RST_WORD;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & err;
      if (acc_first) begin
        prdata_q <= (pwrite | err) ? `CCR_RST_WORD : rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= `CCR_RST_PRESC;
    end else if (acc_done & pwrite & ctrl_hit) begin
      presc_q <= pwdata[`CCR_PRESC_MSB:`CCR_PRESC_LSB];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_a_low;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && lo_hit[0]) |=> prdata_q == {24'h0, $past(shadow_q[0])};
  endproperty
  a_a_low: assert property (p_a_low) else $error("output a low read wrong");

  property p_low_shadow;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && lo_hit[1]) |=> ##1 prdata_q[7:0] == $past(shadow_q[1], 2);
  endproperty
  a_low_shadow: assert property (p_low_shadow) else $error("low read not from shadow");

  property p_a_high;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && paddr == 8'h4C) |=> pready_q && prdata_q == {24'h0, $past(cnt[0][15:8])};
  endproperty
  a_a_high: assert property (p_a_high) else $error("output a high read wrong");

  property p_b_act;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && paddr == 8'h54) |=> prdata_q[7:0] == $past(cnt[1][15:8]);
  endproperty
  a_b_act: assert property (p_b_act) else $error("output b active high read wrong");

  property p_b_slp;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && paddr == 8'h5C) |=> prdata_q[7:0] == $past(cnt[2][15:8]);
  endproperty
  a_b_slp: assert property (p_b_slp) else $error("output b sleep high read wrong");

  property p_inh;
    @(posedge pclk) disable iff (!presetn)
    (psel && paddr == 8'h50) |-> inh[0] && !inh[1] && !inh[2];
  endproperty
  a_inh: assert property (p_inh) else $error("addressed counter not held");

  // ----------------------------------------
  // bus, prescaler and pin sync checks
  // ----------------------------------------
  property p_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    prdata_q[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data above byte not zero");

  property p_rdy_wait;
    @(posedge pclk) disable iff (!presetn)
    acc_first |=> pready_q;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait");

  property p_rdy_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held over one cycle");

  property p_err_rdy;
    @(posedge pclk) disable iff (!presetn)
    pslverr_q |-> pready_q && prdata_q == 32'h00000000;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready or with data");

  property p_ro_write;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && pwrite && !ctrl_hit) |=> pslverr_q;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to read only not refused");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !mapped) |=> pslverr_q && prdata_q == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_err_clear;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !err) |=> !pslverr_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error on a legal access");

  property p_presc_set;
    @(posedge pclk) disable iff (!presetn)
    (acc_done && pwrite && ctrl_hit) |=>
      presc_q == $past(pwdata[`CCR_PRESC_MSB:`CCR_PRESC_LSB]);
  endproperty
  a_presc_set: assert property (p_presc_set) else $error("prescaler write lost");

  property p_presc_keep;
    @(posedge pclk) disable iff (!presetn)
    !(acc_done && pwrite && ctrl_hit) |=> presc_q == $past(presc_q);
  endproperty
  a_presc_keep: assert property (p_presc_keep) else $error("prescaler moved");

  property p_presc_rd;
    @(posedge pclk) disable iff (!presetn)
    (acc_first && !pwrite && ctrl_hit) |=> prdata_q == {29'h0, $past(presc_q)};
  endproperty
  a_presc_rd: assert property (p_presc_rd) else $error("prescaler read wrong");

  // read data must stand until the next access, software may sample late
  property p_data_keep;
    @(posedge pclk) disable iff (!presetn)
    !acc_first |=> prdata_q == $past(prdata_q);
  endproperty
  a_data_keep: assert property (p_data_keep) else $error("read data moved between reads");

  property p_sync_lat;
    @(posedge pclk) disable iff (!presetn)
    (pa_s == $past(pulse_a, 2)) && (pb_s == $past(pulse_b, 2)) &&
      (sleep_s == $past(mode_deep_sleep, 2));
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("pin sync latency not two");
endmodule : ccr_top

/* File: shared/ccr_defs.svh */
// Overview of operation
// - output A low byte in bits 7:0
// - one count per prescaler-selected pulse group
// - addressed counter stops updating during access
// - high byte read snapshots low byte
// - low byte read returns the shadow
// - output B active counter at 0x15/0x16
// - output A high byte at 0x13
// - output B deep sleep counter at 0x17
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ----------------------------------------
// register indices, byte address is index * 4
// ----------------------------------------
`define CCR_IDX_A_HIGH      6'h13
`define CCR_IDX_A_LOW       6'h14
`define CCR_IDX_B_ACT_HIGH  6'h15
`define CCR_IDX_B_ACT_LOW   6'h16
`define CCR_IDX_B_SLP_HIGH  6'h17
`define CCR_IDX_B_SLP_LOW   6'h18
`define CCR_IDX_CTRL        6'h20
`define CCR_IDX_STAT        6'h21

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CCR_PRESC_MSB       2
`define CCR_PRESC_LSB       0
`define CCR_STAT_MODE_BIT   0
`define CCR_STAT_PA_BIT     1
`define CCR_STAT_PB_BIT     2
`define CCR_RST_BYTE        8'h00
`define CCR_RST_COUNT       16'h0000
`define CCR_RST_PRESC       3'h0
`define CCR_RST_WORD        32'h00000000
`define CCR_NUM_COUNTERS    3
`define CCR_SYNC_W          3

`endif

/* File: shared/ccr_pkg.sv */
package ccr_pkg;
  typedef logic [7:0]  ccr_byte_t;
  typedef logic [15:0] ccr_count_t;
  typedef logic [5:0]  ccr_idx_t;
  typedef logic [2:0]  ccr_presc_t;
  typedef logic [31:0] ccr_word_t;
endpackage : ccr_pkg

/* File: hdl/ccr_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------
// two flop synchroniser for pin levels
// ----------------------------------------
module ccr_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : ccr_sync

/* File: hdl/ccr_counter.sv */
`timescale 1ns/1ps
`include "ccr_defs.svh"
// ----------------------------------------
// prescaled 16-bit charge counter with hold
// ----------------------------------------
module ccr_counter (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                pulse_lvl,
  input  wire ccr_pkg::ccr_presc_t prescale,
  input  wire logic                count_en,
  input  wire logic                inhibit,
  output ccr_pkg::ccr_count_t      count_q
);
  logic       pulse_q;
  logic [6:0] pre_q;
  logic [7:0] lim;
  logic [6:0] lim_m1;
  logic       tick;
  logic       wrap;

  assign lim    = 8'h01 << prescale;
  assign lim_m1 = lim[6:0] - 7'h01;
  // pulses seen while held are dropped, never queued: software must keep accesses short
  assign tick   = pulse_lvl & ~pulse_q & count_en & ~inhibit;
  assign wrap   = tick & (pre_q >= lim_m1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
      pre_q   <= 7'h00;
      count_q <= `CCR_RST_COUNT;
    end else begin
      pulse_q <= pulse_lvl;
      if (wrap) begin
        pre_q   <= 7'h00;
        count_q <= count_q + 16'h0001;
      end else if (tick) begin
        pre_q   <= pre_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    inhibit |=> count_q == $past(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while held");

  property p_unit;
    @(posedge pclk) disable iff (!presetn)
    (count_q != $past(count_q)) |-> (count_q == $past(count_q) + 16'h0001) && $past(wrap);
  endproperty
  a_unit: assert property (p_unit) else $error("counter step not one prescaled unit");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    ($fell(inhibit) && wrap) |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume from held value");
endmodule : ccr_counter

/* File: verif/ccr_pulse_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// converter pulse source, n rises 4 cycles apart
// ----------------------------------------
module ccr_pulse_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] n,
  output logic             pin_q,
  output logic             busy
);
  logic [15:0] left_q;
  logic [1:0]  ph_q;
  assign busy = (left_q != 16'h0000);
  // pin falls back low after every burst, never parks high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 16'h0000;
      ph_q   <= 2'h0;
      pin_q  <= 1'b0;
    end else if (start && !busy) begin
      left_q <= n;
      ph_q   <= 2'h0;
    end else if (busy) begin
      ph_q  <= ph_q + 2'h1;
      pin_q <= ~ph_q[1];
      if (ph_q == 2'h3) left_q <= left_q - 16'h0001;
    end
  end
endmodule : ccr_pulse_src

/* File: verif/ccr_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ccr_bench;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic               mode = 0, go_a = 0, go_b = 0, err;
  logic               hold_sel = 0;
  logic               pready_q, pslverr_q, pin_a, pin_b, busy_a, busy_b;
  logic [7:0]         paddr = 8'h00;
  logic [15:0]        n_p = 16'h0000;
  ccr_pkg::ccr_word_t pwdata = 32'h00000000, rd, prdata_q;
  int                 n_errors = 0, n_compared = 0, seed = 5, presc = 0;
  int                 cnt[3] = '{0, 0, 0}, shd[3] = '{0, 0, 0}, pre[3] = '{0, 0, 0};
  ccr_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .pulse_a(pin_a), .pulse_b(pin_b),
    .mode_deep_sleep(mode));
  ccr_pulse_src u_src_a (.pclk(pclk), .presetn(presetn), .start(go_a), .n(n_p),
    .pin_q(pin_a), .busy(busy_a));
  ccr_pulse_src u_src_b (.pclk(pclk), .presetn(presetn), .start(go_b), .n(n_p),
    .pin_q(pin_b), .busy(busy_b));
  initial begin
    forever #10 pclk = ~pclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic apb(input logic [7:0] a, input logic w, input ccr_pkg::ccr_word_t d);
    int i;
    paddr <= a; pwrite <= w; pwdata <= d;
    if (!psel) psel <= 1'b1;
    @(posedge pclk); penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready_q === 1'b1) break;
    end
    if (i == 20) begin n_errors++; close_out(); end
    rd = prdata_q; err = pslverr_q; penable <= 1'b0;
    // back to back: psel stays up and the next setup follows this edge
    if (!hold_sel) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  // counters are read only here; bad also addresses them, with refused writes
  task automatic rd_reg(input int idx);
    int k;
    ccr_pkg::ccr_word_t e;
    k = (idx - 'h13) / 2;
    apb({idx[5:0], 2'b00}, 1'b0, 32'h00000000);
    if (idx >= 'h13 && idx <= 'h18) begin
      if ((idx - 'h13) % 2 == 0) begin e = cnt[k] >> 8; shd[k] = cnt[k] & 'hFF; end
      else e = shd[k];
    end else if (idx == 'h20) e = presc;
    else e = {31'h0, mode};
    `CHK(rd, e)
    `CHK(err, 1'b0)
  endtask : rd_reg
  task automatic pulses(input int b, input int n);
    int i, k;
    k = b ? (mode ? 2 : 1) : 0;
    n_p <= n[15:0]; go_a <= !b; go_b <= b;
    @(posedge pclk); go_a <= 1'b0; go_b <= 1'b0;
    for (i = 0; i < 4000 && (i == 0 || busy_a || busy_b); i++) @(posedge pclk);
    if (i == 4000) begin n_errors++; close_out(); end
    repeat (8) @(posedge pclk);
    for (i = 0; i < n; i++) begin
      pre[k]++;
      if (pre[k] >= (1 << presc)) begin pre[k] = 0; cnt[k] = (cnt[k] + 1) & 'hFFFF; end
    end
  endtask : pulses
  task automatic bad(input logic [7:0] a, input logic w);
    apb(a, w, $random(seed));
    `CHK(err, 1'b1)
    `CHK(rd, 32'h00000000)
  endtask : bad
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int j;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 'h13; i <= 'h18; i++) rd_reg(i);
    rd_reg('h20);
    pulses(0, 256 + ($random(seed) & 'h3F));
    pulses(1, 1 + ($random(seed) & 'h3F));
    for (int i = 'h13; i <= 'h18; i++) rd_reg(i);
    // low byte must come from the snapshot, not the live count
    rd_reg('h13); pulses(0, 5); rd_reg('h14); rd_reg('h14); rd_reg('h13); rd_reg('h14);
    mode <= 1'b1;
    repeat (6) @(posedge pclk);
    pulses(1, 30);
    rd_reg('h21);
    for (int i = 'h15; i <= 'h18; i++) rd_reg(i);
    apb(8'h80, 1'b1, ($random(seed) & 32'hFFFFFFF8) | 32'h00000002);
    presc = 2;
    `CHK(err, 1'b0)
    rd_reg('h20); pulses(0, 8); rd_reg('h13); rd_reg('h14);
    bad(8'h64, 1'b0); bad(8'h4D, 1'b0); bad(8'h4C, 1'b1); bad(8'h54, 1'b1);
    // reads kept back to back over a whole burst: every pulse lands in the hold and is lost
    hold_sel = 1'b1;
    n_p <= 16'h000C;
    go_a <= 1'b1;
    rd_reg('h13);
    go_a <= 1'b0;
    for (j = 0; j < 100 && busy_a; j++) rd_reg('h13);
    if (j == 100) begin n_errors++; close_out(); end
    hold_sel = 1'b0;
    rd_reg('h14);
    rd_reg('h13); rd_reg('h14);
    close_out();
  end
endmodule : ccr_bench
